// >>> design/hsr_nv_store.v
// Small image of the configuration registers, cleared to zero on reset.
// Assumes the same clock and synchronised reset as the sequencer; read data registered.
`timescale 1ns/10ps
module hsr_nv_store (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       wr_en,
  input  wire [1:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire [1:0] rd_addr,
  output reg  [7:0] rd_data
);
  reg [7:0] mem [0:3];
  integer   i;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        mem[i] <= 8'h00;
      end
      rd_data <= 8'h00;
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule // hsr_nv_store

// >>> design/hsr_reboot_seq.v
// Reboot sequencer of the hot swap controller with its two setup registers and its reboot control register.
// Assumes a byte-wide register port from the management bus front end on clk.
`include "hsr_regs.vh"
`timescale 1ns/10ps
module hsr_reboot_seq (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       nv_store,
  output reg  [7:0] reg_rdata,
  output reg        switch_on,
  output reg  [6:0] startup_limit_pct,
  output reg [15:0] fault_timeout_ms,
  output reg  [7:0] drain_threshold_mv,
  output reg        reloading
);
  localparam ST_RUN    = 4'b0001;
  localparam ST_WAIT   = 4'b0010;
  localparam ST_RELOAD = 4'b0100;
  localparam ST_DONE   = 4'b1000;

  // ****************************************
  // Reset release
  // ****************************************
  reg rst_s1;
  reg rst_sync_n;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1     <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1     <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  // ****************************************
  // Decoders
  // ****************************************
  function [16:0] wait_ms;
    input [2:0]  code;
    reg   [31:0] full;
    begin
      full    = `HSR_MIN_WAIT_MS << code;
      // Longest code needs 17 bits; the upper bits are always zero
      wait_ms = full[16:0];
    end
  endfunction

  function [6:0] fb_pct;
    input [1:0] code;
    begin
      case (code)
        `HSR_FB_TENTH: fb_pct = 7'd10;
        `HSR_FB_FIFTH: fb_pct = 7'd20;
        `HSR_FB_FULL:  fb_pct = 7'd100;
        default:       fb_pct = 7'd50;
      endcase
    end
  endfunction

  function [15:0] tmo_ms;
    input [1:0] code;
    begin
      case (code)
        `HSR_TMO_512MS: tmo_ms = 16'd512;
        2'b10:          tmo_ms = 16'd1024;
        2'b11:          tmo_ms = 16'd2048;
        default:        tmo_ms = 16'd256;
      endcase
    end
  endfunction

  function [7:0] dth_mv;
    input [1:0] code;
    begin
      case (code)
        `HSR_DTH_102MV: dth_mv = 8'd102;
        2'b10:          dth_mv = 8'd153;
        2'b11:          dth_mv = 8'd204;
        default:        dth_mv = 8'd72;
      endcase
    end
  endfunction

  // ****************************************
  // Registers and sequencer
  // ****************************************
  reg  [7:0]  limit_setup_a;
  reg  [7:0]  protection_setup_b;
  reg         reboot_request;
  reg  [2:0]  reboot_wait_select;
  reg         wait_pending;
  reg         req_armed;
  reg  [3:0]  state;
  reg  [16:0] tick_div;
  reg  [16:0] ms_left;
  reg  [1:0]  ld_idx;
  reg         ld_valid;
  reg  [1:0]  ld_slot;
  wire [7:0]  nv_rdata;
  wire        ms_tick = (tick_div == `HSR_TICK_CYCLES - 1);
  wire        wr_reboot = reg_wr && reg_addr == `HSR_ADDR_REBOOT_CONTROL;
  wire        start = reboot_request && req_armed && state == ST_RUN;
  reg  [1:0]  nv_wr_addr;
  reg  [7:0]  nv_wr_data;

  always @* begin
    nv_wr_addr = 2'd0;
    nv_wr_data = limit_setup_a;
    if (reg_addr == `HSR_ADDR_PROTECTION_SETUP_B) begin
      nv_wr_addr = 2'd1;
      nv_wr_data = protection_setup_b;
    end
  end

  hsr_nv_store u_nv (
    .clk     (clk),
    .rst_n   (rst_sync_n),
    .wr_en   (nv_store),
    .wr_addr (nv_wr_addr),
    .wr_data (nv_wr_data),
    .rd_addr (ld_idx),
    .rd_data (nv_rdata)
  );

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      limit_setup_a      <= 8'h00;
      protection_setup_b <= 8'h00;
      reboot_request     <= 1'b0;
      reboot_wait_select <= 3'h0;
      wait_pending       <= 1'b0;
      req_armed          <= 1'b1;
      state              <= ST_RUN;
      tick_div           <= 17'h0;
      ms_left            <= 17'h0;
      ld_idx             <= 2'h0;
      ld_valid           <= 1'b0;
      ld_slot            <= 2'h0;
    end else begin
      tick_div <= ms_tick ? 17'h0 : tick_div + 17'h1;
      if (reg_wr && reg_addr == `HSR_ADDR_LIMIT_SETUP_A && state != ST_RELOAD) begin
        limit_setup_a <= reg_wdata;
      end
      if (reg_wr && reg_addr == `HSR_ADDR_PROTECTION_SETUP_B && state != ST_RELOAD) begin
        protection_setup_b <= reg_wdata;
      end
      if (wr_reboot) begin
        reboot_request     <= reg_wdata[`HSR_REQ_BIT];
        reboot_wait_select <= reg_wdata[`HSR_WAIT_HI:`HSR_WAIT_LO];
      end
      ld_valid <= 1'b0;
      case (state)
        ST_RUN: begin
          if (start) begin
            req_armed    <= 1'b0;
            wait_pending <= 1'b1;
            ms_left      <= wait_ms(reboot_wait_select);
            state        <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ms_tick) begin
            if (ms_left == 17'h1) begin
              wait_pending <= 1'b0;
              ld_idx       <= 2'h0;
              ld_slot      <= 2'h0;
              state        <= ST_RELOAD;
            end else begin
              ms_left <= ms_left - 17'h1;
            end
          end
        end
        ST_RELOAD: begin
          // Memory read is one cycle late, so slot trails the address
          if (ld_valid) begin
            case (ld_slot)
              2'd0:    limit_setup_a      <= nv_rdata;
              default: protection_setup_b <= nv_rdata;
            endcase
          end
          if (ld_idx < `HSR_RELOAD_WORDS) begin
            ld_idx   <= ld_idx + 2'h1;
            ld_slot  <= ld_idx;
            ld_valid <= 1'b1;
          end else if (!ld_valid) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Request bit left as is for software to see
          state <= ST_RUN;
        end
        default: state <= ST_RUN;
      endcase
      // Rearm only on a written zero, so a stuck one cannot loop; beats a same-cycle start
      if (wr_reboot && !reg_wdata[`HSR_REQ_BIT]) begin
        req_armed <= 1'b1;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata          <= 8'h00;
      switch_on          <= 1'b0;
      startup_limit_pct  <= 7'd0;
      fault_timeout_ms   <= 16'd0;
      drain_threshold_mv <= 8'd0;
      reloading          <= 1'b0;
    end else begin
      switch_on          <= (state == ST_RUN) && !start;
      reloading          <= (state == ST_RELOAD);
      startup_limit_pct  <= fb_pct(limit_setup_a[`HSR_FOLDBACK_HI:`HSR_FOLDBACK_LO]);
      fault_timeout_ms   <= tmo_ms(protection_setup_b[`HSR_FAULT_TMO_HI:`HSR_FAULT_TMO_LO]);
      drain_threshold_mv <= dth_mv(protection_setup_b[`HSR_DRAIN_TH_HI:`HSR_DRAIN_TH_LO]);
      if (reg_rd) begin
        case (reg_addr)
          `HSR_ADDR_LIMIT_SETUP_A:      reg_rdata <= limit_setup_a;
          `HSR_ADDR_PROTECTION_SETUP_B: reg_rdata <= protection_setup_b;
          `HSR_ADDR_REBOOT_CONTROL:     reg_rdata <= {reboot_request, wait_pending, 3'b000, reboot_wait_select};
          default:                      reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // hsr_reboot_seq

// >>> design/hsr_regs.vh
// Register map, field layout and timing constants of the reboot sequencer.
// Assumes a 100 MHz core clock; included by the sequencer.
`ifndef HSR_REGS_VH
`define HSR_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define HSR_ADDR_LIMIT_SETUP_A      8'h0d
`define HSR_ADDR_PROTECTION_SETUP_B 8'h0e
`define HSR_ADDR_REBOOT_CONTROL     8'ha2

// ****************************************
// Field positions
// ****************************************
`define HSR_FOLDBACK_LO     1
`define HSR_FOLDBACK_HI     2
`define HSR_FAULT_TMO_LO    0
`define HSR_FAULT_TMO_HI    1
`define HSR_DRAIN_TH_LO     2
`define HSR_DRAIN_TH_HI     3
`define HSR_REQ_BIT         7
`define HSR_PEND_BIT        6
`define HSR_WAIT_LO         0
`define HSR_WAIT_HI         2

// ****************************************
// Encodings
// ****************************************
`define HSR_FB_TENTH        2'b01
`define HSR_FB_FIFTH        2'b10
`define HSR_FB_NONE         2'b00
`define HSR_FB_FULL         2'b11
`define HSR_TMO_512MS       2'b01
`define HSR_DTH_102MV       2'b01

// ****************************************
// Timing
// ****************************************
`define HSR_CLK_MHZ         100
`define HSR_TICK_US         1000
`define HSR_TICK_CYCLES     (`HSR_CLK_MHZ * `HSR_TICK_US)
`define HSR_MIN_WAIT_MS     512
`define HSR_RELOAD_WORDS    2

`endif

// >>> dv/hsr_properties.sv
// Port checker for the reboot sequencer.
// Assumes it is bound to hsr_reboot_seq and sees only its ports.
`timescale 1ns/10ps
module hsr_checker (
  input wire        clk,
  input wire        rst_n,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata,
  input wire        switch_on,
  input wire [6:0]  startup_limit_pct,
  input wire [15:0] fault_timeout_ms,
  input wire [7:0]  drain_threshold_mv,
  input wire        reloading
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wa = reg_wr && !reloading && reg_addr == 8'h0d;
  wire wb = reg_wr && !reloading && reg_addr == 8'h0e;
  wire wq = reg_wr && reg_addr == 8'ha2;
  wire ra = reg_rd && reg_addr == 8'ha2;
  // Last request value written since reset
  reg  req_seen;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_seen <= 1'b0;
    end else if (wq) begin
      req_seen <= reg_wdata[7];
    end
  end
  // Quiet cycles after a write so a later write cannot mask the result
  a_fold_tenth: assert property (wa && reg_wdata[2:1] == 2'b01 ##1 (!reg_wr && !reloading)[*3] |-> startup_limit_pct == 7'd10)
    else $error("foldback tenth wrong");
  a_fold_fifth: assert property (wa && reg_wdata[2:1] == 2'b10 ##1 (!reg_wr && !reloading)[*3] |-> startup_limit_pct == 7'd20)
    else $error("foldback fifth wrong");
  a_timeout_select: assert property (wb && reg_wdata[1:0] == 2'b01 ##1 (!reg_wr && !reloading)[*3] |-> fault_timeout_ms == 16'd512)
    else $error("fault timeout wrong");
  a_drain_select: assert property (wb && reg_wdata[3:2] == 2'b01 ##1 (!reg_wr && !reloading)[*3] |-> drain_threshold_mv == 8'd102)
    else $error("drain threshold wrong");
  a_pend_switch_off: assert property (ra ##1 reg_rdata[6] |-> !switch_on)
    else $error("switch on while pending");
  a_req_stays_set: assert property (ra && req_seen |=> reg_rdata[7])
    else $error("request bit lost");
  a_reload_switch_off: assert property (reloading |-> !switch_on)
    else $error("switch on while reloading");
  a_wait_holds: assert property ($fell(switch_on) |-> (!switch_on)[*8])
    else $error("wait ended too soon");
  cover property (ra ##1 reg_rdata[6]);
  cover property ($fell(switch_on));
  cover property (wb && reg_wdata[1:0] == 2'b01);
endmodule // hsr_checker

bind hsr_reboot_seq hsr_checker hsr_checker_i (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .switch_on(switch_on),
  .startup_limit_pct(startup_limit_pct), .fault_timeout_ms(fault_timeout_ms),
  .drain_threshold_mv(drain_threshold_mv), .reloading(reloading));

// >>> dv/tb.sv
// Self-checking bench for the reboot sequencer.
// Assumes the design and the bound checker are compiled first.
`timescale 1ns/10ps
module tb;
  reg         clk = 0;
  reg         rst_n = 0;
  reg         reg_wr = 0;
  reg         reg_rd = 0;
  reg         nv_store = 0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [7:0]  reg_wdata = 8'h00;
  wire [7:0]  reg_rdata;
  wire        switch_on;
  wire [6:0]  startup_limit_pct;
  wire [15:0] fault_timeout_ms;
  wire [7:0]  drain_threshold_mv;
  wire        reloading;
  integer     mismatches = 0;
  integer     num_checks = 0;
  integer     i;
  reg  [7:0]  d;
  reg         rd_d = 0;
  logic [7:0] exp_q[$];
  reg  [6:0]  fold_t [0:3] = '{7'd50, 7'd10, 7'd20, 7'd100};
  reg  [15:0] tmo_t [0:3] = '{16'd256, 16'd512, 16'd1024, 16'd2048};
  reg  [7:0]  dth_t [0:3] = '{8'd72, 8'd102, 8'd153, 8'd204};

  // Stored image is written here; its reload only follows a full wait, beyond this run
  hsr_reboot_seq hsr_reboot_seq_i (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .nv_store(nv_store), .reg_rdata(reg_rdata),
    .switch_on(switch_on), .startup_limit_pct(startup_limit_pct), .fault_timeout_ms(fault_timeout_ms),
    .drain_threshold_mv(drain_threshold_mv), .reloading(reloading));

  initial forever #5 clk = ~clk;

  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input [7:0] a, input [7:0] v);
    @(negedge clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 0;
  endtask

  task rd(input [7:0] a, input [7:0] e);
    @(negedge clk);
    reg_rd = 1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge clk);
    reg_rd = 0;
  endtask

  task nvs(input [7:0] a);
    @(negedge clk);
    nv_store = 1;
    reg_addr = a;
    @(negedge clk);
    nv_store = 0;
  endtask

  task results;
    $display("mismatches %0d checks %0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Read data is looked at one edge after the read is taken
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) check(reg_rdata, exp_q.pop_front());
  end

  initial begin
    d = $urandom(32'he571);
    repeat (5) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    check(switch_on, 1'b1);
    // Low nibble walks every code pair; upper bits random
    for (i = 0; i < 16; i++) begin
      d = $urandom;
      d[3:0] = i[3:0];
      wr(8'h0d, d);
      wr(8'h0e, d);
      repeat (3) @(negedge clk);
      check(startup_limit_pct, fold_t[d[2:1]]);
      check(fault_timeout_ms, tmo_t[d[1:0]]);
      check(drain_threshold_mv, dth_t[d[3:2]]);
      rd(8'h0d, d);
      rd(8'h0e, d);
    end
    rd(8'h55, 8'h00);
    rd(8'ha2, 8'h00);
    // Timeout above the load charge time, then kept in the stored image
    d = $urandom;
    d[1:0] = 2'h1;
    wr(8'h0e, d);
    nvs(8'h0e);
    nvs(8'h0d);
    repeat (2) @(negedge clk);
    check(fault_timeout_ms, 16'h0200);
    rd(8'h0e, d);
    d = $urandom;
    d = {5'h10, d[2:0]};
    wr(8'ha2, d);
    repeat (4) @(negedge clk);
    check(switch_on, 1'b0);
    rd(8'ha2, d | 8'h40);
    // Even the shortest wait is far beyond this run, so it must still be pending
    repeat (1000) @(negedge clk);
    check(switch_on, 1'b0);
    check(reloading, 1'b0);
    rd(8'ha2, d | 8'h40);
    // Reset in mid-wait drops the request; a zero then a one starts afresh
    @(negedge clk);
    rst_n = 0;
    repeat (5) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    check(switch_on, 1'b1);
    rd(8'ha2, 8'h00);
    d = $urandom;
    d = {5'h10, d[2:0]};
    wr(8'ha2, 8'h00);
    wr(8'ha2, d);
    repeat (4) @(negedge clk);
    check(switch_on, 1'b0);
    rd(8'ha2, d | 8'h40);
    @(negedge clk);
    results;
  end

  initial begin
    #100000;
    mismatches++;
    results;
  end
endmodule // tb
